// [scpim_edge.sv]
// Rising-edge detector giving a one-cycle pulse per edge
`timescale 1ns/100ps
module scpim_edge
    import scpim_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] rise_out
);

    logic [WIDTH-1:0] prev_q;

    // Previous sample of the synchronised level
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prev_q <= '0;
        end else begin
            prev_q <= level_in;
        end
    end

    assign rise_out = level_in & ~prev_q;

endmodule

// [scpim_pkg.sv]
// Package of constants and types for the control processor interrupt map
package scpim_pkg;

    // Width of the interrupt vector presented to the interrupt controller
    localparam int SCPIM_NUM_IRQ = 50;
    // Depth of each input synchroniser
    localparam int SCPIM_SYNC_STAGES = 2;

    // Interrupt input numbers
    localparam int SCPIM_IRQ_DBG_PWRUP = 1;
    localparam int SCPIM_IRQ_SYS_PWRUP = 2;
    localparam int SCPIM_IRQ_DBG_RST = 3;
    localparam int SCPIM_IRQ_CLUSTER = 8;
    localparam int SCPIM_IRQ_CORE = 9;
    localparam int SCPIM_IRQ_WAKE_LO = 16;
    localparam int SCPIM_IRQ_WAKE_HI = 31;
    localparam int SCPIM_IRQ_PWR_CTRL = 32;
    localparam int SCPIM_IRQ_TIMER = 33;
    localparam int SCPIM_IRQ_MSG_HP_NS = 34;
    localparam int SCPIM_IRQ_MSG_LP_NS = 35;
    localparam int SCPIM_IRQ_MSG_S = 36;
    localparam int SCPIM_IRQ_XTRIG0 = 37;
    localparam int SCPIM_IRQ_XTRIG1 = 38;
    localparam int SCPIM_IRQ_INTC_FAULT = 39;
    localparam int SCPIM_IRQ_INTC_ERR = 40;
    localparam int SCPIM_IRQ_MC0_ECC = 42;
    localparam int SCPIM_IRQ_MC0_MISC = 43;
    localparam int SCPIM_IRQ_MC0_FILT = 44;
    localparam int SCPIM_IRQ_MC1_ECC = 46;
    localparam int SCPIM_IRQ_MC1_MISC = 47;
    localparam int SCPIM_IRQ_MC1_FILT = 48;

    // Highest input number that can wake the processor
    localparam int SCPIM_WAKE_MAX = 31;

    // Reset values of the outputs
    localparam logic [SCPIM_NUM_IRQ-1:0] SCPIM_IRQ_RST = 50'h0;
    localparam logic [31:0] SCPIM_WAKE_RST = 32'h0;
    // Synchroniser reset pattern, active-low fault pins idle high
    localparam logic [40:0] SCPIM_RAW_RST = 41'h000_01FF_0000;

    // Cluster fault sources, active low at the pins
    typedef struct packed {
        logic partition_monitor_nonsecure_irq_n;
        logic partition_monitor_secure_irq_n;
        logic cluster_critical_irq_n;
        logic cluster_error_irq_n;
        logic cluster_fault_irq_n;
    } scpim_cluster_s;

    // Core and complex fault sources, active low at the pins
    typedef struct packed {
        logic per_core_error_irq_n;
        logic complex_error_irq_n;
        logic per_core_fault_irq_n;
        logic complex_fault_irq_n;
    } scpim_core_s;

    // Message channel requests
    typedef struct packed {
        logic hp_nonsecure;
        logic lp_nonsecure;
        logic secure;
    } scpim_msg_s;

    // Memory controller requests
    typedef struct packed {
        logic ecc_err;
        logic misc_access;
        logic addr_filter;
    } scpim_mc_s;

endpackage

// [scpim_properties.sv]
// Assertions on the interrupt map outputs
`timescale 1ns/100ps
module scpim_top_properties
    import scpim_pkg::*;
#(
    parameter int NUM_IRQ = SCPIM_NUM_IRQ
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic watchdog_irq,
    input wire scpim_cluster_s cluster_irq_n,
    input wire logic ref_timer_irq,
    input wire logic [1:0] cross_trigger,
    input wire logic intc_fault_line,
    input wire logic intc_error_line,
    input wire logic nmi_q,
    input wire logic [NUM_IRQ-1:0] irq_q,
    input wire logic [31:0] wake_q,
    input wire logic nmi_wake_q,
    input wire logic top_domain_reset_req_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_nmi; nmi_q == $past(watchdog_irq, 3); endproperty
    a_nmi: assert property (p_nmi) else $error("nmi lag");
    property p_timer; irq_q[33] == $past(ref_timer_irq, 3); endproperty
    a_timer: assert property (p_timer) else $error("timer lag");
    property p_clus; irq_q[8] == $past(~&cluster_irq_n, 3); endproperty
    a_clus: assert property (p_clus) else $error("cluster line");
    property p_rsv; (irq_q[49:0] & 50'h2_2200_0000_FCF1) == 50'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved set");
    property p_wake; wake_q == irq_q[31:0] && nmi_wake_q == nmi_q; endproperty
    a_wake: assert property (p_wake) else $error("wake copy");
    property p_pulse; irq_q[37] |=> !irq_q[37]; endproperty
    a_pulse: assert property (p_pulse) else $error("long pulse");
    property p_rise; $rose(cross_trigger[1]) |-> ##3 irq_q[38]; endproperty
    a_rise: assert property (p_rise) else $error("no pulse");
    property p_top;
        top_domain_reset_req_q == $past(intc_fault_line | intc_error_line, 3);
    endproperty
    a_top: assert property (p_top) else $error("top reset");
endmodule

// [scpim_src_model.sv]
// Model of the interrupt sources feeding the map
`timescale 1ns/100ps
module scpim_src_model
    import scpim_pkg::*;
(
    input wire logic [43:0] act,
    output logic watchdog_irq,
    output logic dbg_pwrup_req,
    output logic sys_pwrup_req,
    output logic dbg_rst_req,
    output scpim_cluster_s cluster_irq_n,
    output scpim_core_s core_irq_n,
    output logic [15:0] ext_wake_irq,
    output logic pwr_ctrl_irq,
    output logic ref_timer_irq,
    output scpim_msg_s msg_irq,
    output logic [1:0] cross_trigger,
    output logic intc_fault_line,
    output logic intc_error_line,
    output scpim_mc_s mc0_irq,
    output scpim_mc_s mc1_irq
);
    // Source levels from the request vector, faults active low
    assign {dbg_rst_req, sys_pwrup_req, dbg_pwrup_req, watchdog_irq} = act[3:0];
    assign cluster_irq_n = ~act[8:4];
    assign core_irq_n = ~act[12:9];
    assign ext_wake_irq = act[28:13];
    assign {intc_error_line, intc_fault_line, cross_trigger} = act[37:34];
    assign {ref_timer_irq, pwr_ctrl_irq} = act[30:29];
    assign msg_irq = {act[31], act[32], act[33]};
    assign mc0_irq = {act[38], act[39], act[40]};
    assign mc1_irq = {act[41], act[42], act[43]};
endmodule

// [scpim_sync.sv]
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/100ps
module scpim_sync
    import scpim_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage read only by the second stage
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// [scpim_top.sv]
// Interrupt input map of the system control processor
// Notes on behaviour
// RQ1 - Every listed source reaches the interrupt controller
// RQ2 - Watchdog and inputs 0-31 can wake processor
// RQ3 - Inputs 1-3: debug power/reset requests, rising edge
// RQ4 - Input 8: combined cluster faults, level high
// RQ5 - Input 9: combined core faults, level high
// RQ6 - External logic drives wakeup inputs 16-31
// RQ7 - Input 32: power control interrupt, level high
// RQ8 - Input 33: reference clock timer, level high
// RQ9 - Inputs 34-36: message channels, level high
// RQ10 - Inputs 37-38: cross triggers, rising edge
// RQ11 - Inputs 39-40: controller fault/error, reset system top
// RQ12 - Watchdog on non-maskable; memory controller levels
// RQ13 - Reserved inputs tied inactive low
`timescale 1ns/100ps
module scpim_top
    import scpim_pkg::*;
#(
    parameter int NUM_IRQ = SCPIM_NUM_IRQ
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic watchdog_irq,
    input wire logic dbg_pwrup_req,
    input wire logic sys_pwrup_req,
    input wire logic dbg_rst_req,
    input wire scpim_cluster_s cluster_irq_n,
    input wire scpim_core_s core_irq_n,
    input wire logic [15:0] ext_wake_irq,
    input wire logic pwr_ctrl_irq,
    input wire logic ref_timer_irq,
    input wire scpim_msg_s msg_irq,
    input wire logic [1:0] cross_trigger,
    input wire logic intc_fault_line,
    input wire logic intc_error_line,
    input wire scpim_mc_s mc0_irq,
    input wire scpim_mc_s mc1_irq,
    output logic nmi_q,
    output logic [NUM_IRQ-1:0] irq_q,
    output logic [31:0] wake_q,
    output logic nmi_wake_q,
    output logic top_domain_reset_req_q
);

    // Bundle every raw source except the second memory controller into one vector for synchronisation
    localparam int RAW_W = 41;
    logic [RAW_W-1:0] raw_in;
    logic [RAW_W-1:0] syn;

    assign raw_in = {
        ext_wake_irq,            // [40:25]
        cluster_irq_n,           // [24:20]
        core_irq_n,              // [19:16]
        watchdog_irq,            // [15]
        dbg_pwrup_req,           // [14]
        sys_pwrup_req,           // [13]
        dbg_rst_req,             // [12]
        pwr_ctrl_irq,            // [11]
        ref_timer_irq,           // [10]
        msg_irq,                 // [9:7]
        cross_trigger,           // [6:5]
        intc_fault_line,         // [4]
        intc_error_line,         // [3]
        mc0_irq[2],              // [2]
        mc0_irq[1],              // [1]
        mc0_irq[0]               // [0]
    };

    // All pins cross two flip-flops; active-low sources reset high
    scpim_sync #(
        .WIDTH(RAW_W),
        .RST_VAL(SCPIM_RAW_RST)
    ) u_sync_a (
        .mclk(mclk),
        .nrst(nrst),
        .async_in(raw_in),
        .sync_out(syn)
    );

    // Second memory controller synchronised separately
    logic [2:0] mc1_syn;
    scpim_sync #(
        .WIDTH(3),
        .RST_VAL(3'h0)
    ) u_sync_b (
        .mclk(mclk),
        .nrst(nrst),
        .async_in(mc1_irq),
        .sync_out(mc1_syn)
    );

    // Edge sources: three debug requests and two cross triggers
    logic [4:0] edge_lvl;
    logic [4:0] edge_rise;
    assign edge_lvl = {syn[14], syn[13], syn[12], syn[6], syn[5]};

    scpim_edge #(
        .WIDTH(5)
    ) u_edge (
        .mclk(mclk),
        .nrst(nrst),
        .level_in(edge_lvl),
        .rise_out(edge_rise)
    );

    // Combined fault requests, active when any low source asserts
    logic cluster_any;
    logic core_any;
    assign cluster_any = ~&syn[24:20]; // [RQ4]
    assign core_any = ~&syn[19:16]; // [RQ5]

    // Next value of the interrupt vector
    logic [NUM_IRQ-1:0] irq_d;
    always_comb begin
        irq_d = SCPIM_IRQ_RST; // [RQ13]
        irq_d[SCPIM_IRQ_DBG_PWRUP] = edge_rise[4]; // [RQ3]
        irq_d[SCPIM_IRQ_SYS_PWRUP] = edge_rise[3]; // [RQ3]
        irq_d[SCPIM_IRQ_DBG_RST] = edge_rise[2]; // [RQ3]
        irq_d[SCPIM_IRQ_CLUSTER] = cluster_any; // [RQ4]
        irq_d[SCPIM_IRQ_CORE] = core_any; // [RQ5]
        irq_d[SCPIM_IRQ_WAKE_HI:SCPIM_IRQ_WAKE_LO] = syn[40:25]; // [RQ6]
        irq_d[SCPIM_IRQ_PWR_CTRL] = syn[11]; // [RQ7]
        irq_d[SCPIM_IRQ_TIMER] = syn[10]; // [RQ8]
        irq_d[SCPIM_IRQ_MSG_HP_NS] = syn[9]; // [RQ9]
        irq_d[SCPIM_IRQ_MSG_LP_NS] = syn[8]; // [RQ9]
        irq_d[SCPIM_IRQ_MSG_S] = syn[7]; // [RQ9]
        irq_d[SCPIM_IRQ_XTRIG0] = edge_rise[0]; // [RQ10]
        irq_d[SCPIM_IRQ_XTRIG1] = edge_rise[1]; // [RQ10]
        irq_d[SCPIM_IRQ_INTC_FAULT] = syn[4]; // [RQ11]
        irq_d[SCPIM_IRQ_INTC_ERR] = syn[3]; // [RQ11]
        irq_d[SCPIM_IRQ_MC0_ECC] = syn[2]; // [RQ12]
        irq_d[SCPIM_IRQ_MC0_MISC] = syn[1]; // [RQ12]
        irq_d[SCPIM_IRQ_MC0_FILT] = syn[0]; // [RQ12]
        irq_d[SCPIM_IRQ_MC1_ECC] = mc1_syn[2]; // [RQ12]
        irq_d[SCPIM_IRQ_MC1_MISC] = mc1_syn[1]; // [RQ12]
        irq_d[SCPIM_IRQ_MC1_FILT] = mc1_syn[0]; // [RQ12]
    end

    // Registered vector to the interrupt controller
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_q <= SCPIM_IRQ_RST;
        end else begin
            irq_q <= irq_d; // [RQ1]
        end
    end

    // Watchdog drives the non-maskable input
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            nmi_q <= 1'b0;
        end else begin
            nmi_q <= syn[15]; // [RQ12]
        end
    end

    // Wakeup only from the non-maskable input and inputs 0-31
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wake_q <= SCPIM_WAKE_RST;
            nmi_wake_q <= 1'b0;
        end else begin
            wake_q <= irq_d[SCPIM_WAKE_MAX:0]; // [RQ2]
            nmi_wake_q <= syn[15]; // [RQ2]
        end
    end

    // Controller fault or error requests a system top domain reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            top_domain_reset_req_q <= 1'b0;
        end else begin
            top_domain_reset_req_q <= syn[4] | syn[3]; // [RQ11]
        end
    end

endmodule

// [scpim_top_tb_top.sv]
// Testbench for the control processor interrupt map
`timescale 1ns/100ps
module scpim_top_tb_top
    import scpim_pkg::*;
;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [43:0] act = 44'h0;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    logic watchdog_irq, dbg_pwrup_req, sys_pwrup_req, dbg_rst_req;
    logic pwr_ctrl_irq, ref_timer_irq, intc_fault_line, intc_error_line;
    logic nmi_q, nmi_wake_q, top_domain_reset_req_q;
    logic [1:0] cross_trigger;
    logic [15:0] ext_wake_irq;
    logic [49:0] irq_q;
    logic [31:0] wake_q;
    scpim_cluster_s cluster_irq_n;
    scpim_core_s core_irq_n;
    scpim_msg_s msg_irq;
    scpim_mc_s mc0_irq, mc1_irq;
    scpim_src_model i_scpim_src_model (
        .act(act),
        .watchdog_irq(watchdog_irq),
        .dbg_pwrup_req(dbg_pwrup_req),
        .sys_pwrup_req(sys_pwrup_req),
        .dbg_rst_req(dbg_rst_req),
        .cluster_irq_n(cluster_irq_n),
        .core_irq_n(core_irq_n),
        .ext_wake_irq(ext_wake_irq),
        .pwr_ctrl_irq(pwr_ctrl_irq),
        .ref_timer_irq(ref_timer_irq),
        .msg_irq(msg_irq),
        .cross_trigger(cross_trigger),
        .intc_fault_line(intc_fault_line),
        .intc_error_line(intc_error_line),
        .mc0_irq(mc0_irq),
        .mc1_irq(mc1_irq)
    );
    scpim_top i_scpim_top (
        .mclk(mclk),
        .nrst(nrst),
        .watchdog_irq(watchdog_irq),
        .dbg_pwrup_req(dbg_pwrup_req),
        .sys_pwrup_req(sys_pwrup_req),
        .dbg_rst_req(dbg_rst_req),
        .cluster_irq_n(cluster_irq_n),
        .core_irq_n(core_irq_n),
        .ext_wake_irq(ext_wake_irq),
        .pwr_ctrl_irq(pwr_ctrl_irq),
        .ref_timer_irq(ref_timer_irq),
        .msg_irq(msg_irq),
        .cross_trigger(cross_trigger),
        .intc_fault_line(intc_fault_line),
        .intc_error_line(intc_error_line),
        .mc0_irq(mc0_irq),
        .mc1_irq(mc1_irq),
        .nmi_q(nmi_q),
        .irq_q(irq_q),
        .wake_q(wake_q),
        .nmi_wake_q(nmi_wake_q),
        .top_domain_reset_req_q(top_domain_reset_req_q)
    );
    // Clock and hang guard
    initial begin
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end
    // Source index to input number, -1 for the watchdog
    function automatic int mp(int i);
        if (i == 0) return -1;
        if (i < 4) return i;
        if (i < 9) return 8;
        if (i < 13) return 9;
        if (i < 38) return i + 3;
        return (i < 41) ? i + 4 : i + 5;
    endfunction
    function automatic bit edg(int i);
        return (i > 0 && i < 4) || i == 34 || i == 35;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [49:0] g, input logic [49:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_cnt(input int g, input int e);
        compares++;
        if (g != e) begin
            n_fail++;
            $display("MISMATCH t=%0t count %0d exp %0d", $time, g, e);
        end
    endtask
    // Each level source alone, then released
    task automatic t_levels;
        logic [49:0] e;
        for (int i = 0; i < 44; i++) begin
            if (!edg(i)) begin
                e = 50'h0;
                if (i > 0) e[mp(i)] = 1'b1;
                act[i] = 1'b1;
                tick(4);
                chk(irq_q, e);
                chk({16'h0, wake_q, nmi_wake_q, nmi_q},
                    {16'h0, e[31:0], i == 0, i == 0});
                chk({49'h0, top_domain_reset_req_q}, {49'h0, e[39] | e[40]});
                act[i] = 1'b0;
                tick(4);
                chk(irq_q, 50'h0);
            end
        end
    endtask
    // Held edge source gives one pulse, three edges on
    task automatic t_edges;
        int hit;
        int at;
        for (int i = 1; i < 36; i++) begin
            if (edg(i)) begin
                hit = 0;
                at = 0;
                act[i] = 1'b1;
                for (int k = 1; k < 9; k++) begin
                    tick(1);
                    if (irq_q[mp(i)] === 1'b1) begin
                        hit++;
                        at = k;
                    end
                end
                chk_cnt(hit, 1);
                chk_cnt(at, 3);
                act[i] = 1'b0;
                tick(3);
            end
        end
    endtask
    // Reset in mid-run clears a standing request
    task automatic t_reset;
        act[30] = 1'b1;
        tick(4);
        nrst = 1'b0;
        tick(2);
        chk(irq_q, 50'h0);
        chk({16'h0, wake_q, nmi_wake_q, nmi_q}, 50'h0);
        chk({49'h0, top_domain_reset_req_q}, 50'h0);
        act[30] = 1'b0;
        tick(4);
        nrst = 1'b1;
        tick(2);
        chk(irq_q, SCPIM_IRQ_RST);
        chk({49'h0, nmi_q}, 50'h0);
        tick(2);
        chk(irq_q, SCPIM_IRQ_RST);
    endtask
    task automatic close_out;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        tick(6);
        chk(irq_q, SCPIM_IRQ_RST);
        nrst = 1'b1;
        tick(2);
        t_levels();
        t_edges();
        t_reset();
        close_out();
    end
endmodule
bind scpim_top scpim_top_properties #(.NUM_IRQ(NUM_IRQ)) i_scpim_top_properties (
    .mclk(mclk),
    .nrst(nrst),
    .watchdog_irq(watchdog_irq),
    .cluster_irq_n(cluster_irq_n),
    .ref_timer_irq(ref_timer_irq),
    .cross_trigger(cross_trigger),
    .intc_fault_line(intc_fault_line),
    .intc_error_line(intc_error_line),
    .nmi_q(nmi_q),
    .irq_q(irq_q),
    .wake_q(wake_q),
    .nmi_wake_q(nmi_wake_q),
    .top_domain_reset_req_q(top_domain_reset_req_q)
);
